// ---- srcs_sequencer.sv ----
// reset and bus-clock sequencer of the system integration unit
// assumes all inputs synchronous to core_clk_i except rst_pin_i and pll_output_clock_i
// a pin reset reuses the internal drive and hold sequence
`timescale 1ns/1ps
`default_nettype none
module srcs_sequencer import srcs_pkg::*; #(
	parameter int LONG_CYC = LONG_DLY_CYC
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic power_up_pulse_i,
	input wire logic low_voltage_i,
	input wire logic watchdog_ovf_i,
	input wire logic bad_opcode_i,
	input wire logic stop_exec_i,
	input wire logic stop_enable_i,
	input wire logic fetch_unmapped_i,
	input wire logic opcode_fetch_i,
	input wire logic monitor_entry_reset_i,
	input wire logic monitor_mode_i,
	input wire logic rst_test_high_voltage_i,
	input wire logic irq_test_high_voltage_i,
	input wire logic break_i,
	input wire logic short_recovery_bit_i,
	input wire logic stop_wake_i,
	input wire logic pll_select_i,
	input wire logic pll_output_clock_i,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	output logic internal_reset_signal_o,
	output logic bus_clk_o,
	output logic clock_gen_output_o,
	output logic [15:0] reset_vector_o,
	output logic [7:0] reset_cause_register_o,
	output logic [CNT_W-1:0] counter_o,
	output logic watchdog_disable_o
);
	// ==========================================
	// state and counters
	srcs_state_t state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W:0] seq;
	logic [1:0] div;
	logic pin_s1, pin_s2;
	logic [6:0] low_cnt;
	logic long_reset;
	logic int_src;
	logic pin_reset;
	logic pll_s1, pll_s2, pll_s3;
	logic pll_rise;
	// per-source request terms, shared by the sequencer decode and the checks
	logic wd_src;
	logic opc_src;
	logic adr_src;
	logic mon_src;

	// ==========================================
	// request decode
	assign watchdog_disable_o = (monitor_mode_i &&
	    (rst_test_high_voltage_i || irq_test_high_voltage_i)) ||
	    (break_i && rst_test_high_voltage_i);
	assign long_reset = power_up_pulse_i || low_voltage_i;
	assign wd_src = watchdog_ovf_i && !watchdog_disable_o;
	assign opc_src = bad_opcode_i ||
	    (stop_exec_i && !stop_enable_i);
	// a data access to a hole is harmless; only fetches count
	assign adr_src = fetch_unmapped_i && opcode_fetch_i;
	assign mon_src = monitor_entry_reset_i;
	assign int_src = long_reset || wd_src || opc_src || adr_src ||
	    mon_src;

	// ==========================================
	// reset pin synchroniser and low-time measure
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end else begin
			pin_s1 <= rst_pin_i;
			pin_s2 <= pin_s1;
		end
	end
	// the pin is sampled while we drive it too; only count outside drive
	always_ff @(posedge core_clk_i) begin
		if (srst_i || pin_s2 || rst_pin_oe_o)
			low_cnt <= 7'h00;
		else if (low_cnt != 7'(PIN_MIN_LOW_CYC))
			low_cnt <= low_cnt + 7'h01;
	end
	assign pin_reset = (low_cnt == 7'(PIN_MIN_LOW_CYC - 1)) &&
	    !pin_s2 && !rst_pin_oe_o;

	// ==========================================
	// sequencer
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= SRCS_LONG;
			seq <= '0;
		end else if (long_reset) begin
			state <= SRCS_LONG;
			seq <= '0;
		end else if (int_src || pin_reset) begin
			state <= SRCS_DRIVE;
			seq <= '0;
		end else begin
			case (state)
			SRCS_LONG: begin
				if (seq == (CNT_W+1)'(LONG_CYC + PIN_DRIVE_CYC - 1)) begin
					state <= SRCS_HOLD;
					seq <= '0;
				end else
					seq <= seq + 1'b1;
			end
			SRCS_DRIVE: begin
				if (seq == (CNT_W+1)'(PIN_DRIVE_CYC - 1)) begin
					state <= SRCS_HOLD;
					seq <= '0;
				end else
					seq <= seq + 1'b1;
			end
			SRCS_HOLD: begin
				if (seq == (CNT_W+1)'(INTERNAL_RESET_SIGNAL_EXTRA_CYC - 1)) begin
					state <= SRCS_RUN;
					seq <= '0;
				end else
					seq <= seq + 1'b1;
			end
			SRCS_RUN: begin
				if (stop_exec_i && stop_enable_i)
					state <= SRCS_STOP;
			end
			SRCS_STOP: begin
				// delay counted on the shared counter after the wake
				if (stop_wake_i || seq[0])
					seq <= '0 | 1'b1;
				if (seq[0] && (short_recovery_bit_i ?
				    cnt == CNT_W'(SHORT_DLY_CYC - 1) :
				    cnt == CNT_W'(LONG_CYC - 1))) begin
					state <= SRCS_RUN;
					seq <= '0;
				end
			end
			default: begin
				state <= SRCS_LONG;
				seq <= '0;
			end
			endcase
		end
	end

	// ==========================================
	// free-running counter, watchdog prescaler
	always_ff @(posedge core_clk_i) begin
		if (srst_i || int_src)
			cnt <= '0;
		else if (state == SRCS_RUN && stop_exec_i && stop_enable_i)
			cnt <= '0;
		else if (state == SRCS_STOP && stop_wake_i)
			cnt <= '0;
		else
			cnt <= cnt + 1'b1;
	end
	assign counter_o = cnt;

	// ==========================================
	// cause flags
	always_ff @(posedge core_clk_i) begin
		if (srst_i || power_up_pulse_i) begin
			reset_cause_register_o <= CAUSE_RESET;
		end else if (int_src || pin_reset) begin
			reset_cause_register_o <= '0;
			reset_cause_register_o[B_LV] <= low_voltage_i;
			reset_cause_register_o[B_WDOG] <= watchdog_ovf_i &&
			    !watchdog_disable_o;
			reset_cause_register_o[B_OPC] <= bad_opcode_i ||
			    (stop_exec_i && !stop_enable_i);
			reset_cause_register_o[B_ADR] <= fetch_unmapped_i &&
			    opcode_fetch_i;
			reset_cause_register_o[B_MON] <= monitor_entry_reset_i;
			reset_cause_register_o[B_PIN] <= pin_reset && !long_reset;
		end
	end

	// ==========================================
	// outputs
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pll_s1 <= 1'b0;
			pll_s2 <= 1'b0;
			pll_s3 <= 1'b0;
			div <= 2'b00;
		end else begin
			pll_s1 <= pll_output_clock_i;
			pll_s2 <= pll_s1;
			pll_s3 <= pll_s2;
			// pll source counted by rising edges: gating, not a true clock
			if (!pll_select_i || pll_rise)
				div <= div + 2'b01;
		end
	end
	// pll must run at no more than half the oscillator rate to be seen at all
	assign pll_rise = pll_s2 && !pll_s3;
	assign bus_clk_o = div[1] && state == SRCS_RUN;
	assign clock_gen_output_o = 1'b1;
	assign rst_pin_oe_o = state == SRCS_LONG || state == SRCS_DRIVE;
	assign rst_pin_o = 1'b0;
	assign internal_reset_signal_o = state == SRCS_LONG ||
	    state == SRCS_DRIVE || state == SRCS_HOLD ||
	    (!pin_s2 && !rst_pin_oe_o);
	assign reset_vector_o = monitor_mode_i ? VEC_MONITOR : VEC_NORMAL;

	// ==========================================
	// checks
	// reset sequence lengths and entry, bus clock hold, pll divider step and vector select
	a_pin_drive_len: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) $rose(state == SRCS_HOLD) &&
	    $past(state) == SRCS_DRIVE && !int_src |-> $past(seq) ==
	    (CNT_W+1)'(PIN_DRIVE_CYC - 1))
	    else $error("pin drive length wrong");
	a_hold_release: assert property (@(posedge core_clk_i)
	    disable iff (srst_i || int_src || pin_reset)
	    state == SRCS_HOLD && seq == (CNT_W+1)'(INTERNAL_RESET_SIGNAL_EXTRA_CYC - 1)
	    |=> state == SRCS_RUN)
	    else $error("hold did not release");
	a_long_len: assert property (@(posedge core_clk_i)
	    disable iff (srst_i || int_src || pin_reset)
	    state == SRCS_LONG &&
	    seq == (CNT_W+1)'(LONG_CYC + PIN_DRIVE_CYC - 1)
	    |=> state == SRCS_HOLD)
	    else $error("long drive length wrong");
	a_long_entry: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) long_reset |=> state == SRCS_LONG &&
	    rst_pin_oe_o && !bus_clk_o)
	    else $error("long reset not entered");
	a_drive_entry: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) (wd_src || opc_src || adr_src) &&
	    !long_reset |=> state == SRCS_DRIVE && rst_pin_oe_o)
	    else $error("internal reset did not drive pin");
	a_hold_nodrive: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) state == SRCS_HOLD |->
	    !rst_pin_oe_o && internal_reset_signal_o)
	    else $error("hold phase wrong");
	a_clk_held: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) state != SRCS_RUN |-> !bus_clk_o)
	    else $error("bus clock ran in reset");
	a_pll_hold: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) pll_select_i && !pll_rise |=>
	    div == $past(div))
	    else $error("bus divider stepped without pll edge");
	a_internal_reset_signal_pin: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) !pin_s2 |-> internal_reset_signal_o)
	    else $error("pin low without internal reset");
	a_vector_sel: assert property (@(posedge core_clk_i)
	    monitor_mode_i |-> reset_vector_o == VEC_MONITOR)
	    else $error("vector wrong");
	a_vector_norm: assert property (@(posedge core_clk_i)
	    !monitor_mode_i |-> reset_vector_o == VEC_NORMAL)
	    else $error("normal vector wrong");

	// cause flags
	a_por_flags: assert property (@(posedge core_clk_i)
	    power_up_pulse_i |=> reset_cause_register_o == CAUSE_RESET)
	    else $error("power-on flags wrong");
	a_wd_flag: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) watchdog_ovf_i && !watchdog_disable_o &&
	    !power_up_pulse_i |=> reset_cause_register_o[B_WDOG])
	    else $error("watchdog flag missing");
	a_pin_flag: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) pin_reset && !long_reset |=>
	    reset_cause_register_o[B_PIN])
	    else $error("pin flag missing");
	a_opc_flag: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) opc_src && !power_up_pulse_i |=>
	    reset_cause_register_o[B_OPC])
	    else $error("bad opcode flag missing");
	a_adr_flag: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) adr_src && !power_up_pulse_i |=>
	    reset_cause_register_o[B_ADR])
	    else $error("bad address flag missing");
	a_mon_drive: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) mon_src && !long_reset |=>
	    reset_cause_register_o[B_MON] && state == SRCS_DRIVE)
	    else $error("monitor entry reset missing");
	a_lv_flag: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) low_voltage_i && !power_up_pulse_i |=>
	    reset_cause_register_o[B_LV])
	    else $error("low voltage flag missing");

	// counter and stop recovery
	a_int_clear: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) int_src |=> cnt == '0)
	    else $error("counter not cleared");
	a_pin_keeps: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) pin_reset && !int_src &&
	    !stop_exec_i && !stop_wake_i |=>
	    cnt == $past(cnt) + 1'b1)
	    else $error("pin reset touched counter");
	a_cnt_free: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) state == SRCS_RUN && !int_src &&
	    !stop_exec_i |=>
	    cnt == $past(cnt) + 1'b1)
	    else $error("counter not free running");
	a_stop_entry: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) state == SRCS_RUN && stop_exec_i &&
	    stop_enable_i && !int_src && !pin_reset |=>
	    cnt == '0 && state == SRCS_STOP)
	    else $error("stop entry wrong");
	a_stop_wait: assert property (@(posedge core_clk_i)
	    disable iff (srst_i || int_src || pin_reset)
	    state == SRCS_STOP && !seq[0] && !stop_wake_i |=>
	    state == SRCS_STOP)
	    else $error("stop left without wake");
	a_stop_short: assert property (@(posedge core_clk_i)
	    disable iff (srst_i || int_src || pin_reset)
	    state == SRCS_STOP && seq[0] && short_recovery_bit_i &&
	    cnt == CNT_W'(SHORT_DLY_CYC - 1) |=> state == SRCS_RUN)
	    else $error("short stop delay wrong");
	// data accesses to holes must not disturb the run state
	a_data_noreset: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) state == SRCS_RUN && !int_src &&
	    !pin_reset |=> state == SRCS_RUN || state == SRCS_STOP)
	    else $error("spurious reset");
	a_wd_gated: assert property (@(posedge core_clk_i)
	    disable iff (srst_i) state == SRCS_RUN && watchdog_ovf_i &&
	    watchdog_disable_o && !long_reset && !opc_src && !adr_src &&
	    !mon_src && !pin_reset && !stop_exec_i |=>
	    state == SRCS_RUN)
	    else $error("disabled watchdog caused reset");

	// scenario coverage
	c_long: cover property (@(posedge core_clk_i)
	    state == SRCS_LONG ##1 state == SRCS_HOLD);
	c_pin: cover property (@(posedge core_clk_i) pin_reset);
	c_stop: cover property (@(posedge core_clk_i)
	    state == SRCS_STOP ##1 state == SRCS_RUN);
	c_short_stop: cover property (@(posedge core_clk_i)
	    state == SRCS_STOP && short_recovery_bit_i ##1 state == SRCS_RUN);
	c_wdog: cover property (@(posedge core_clk_i)
	    wd_src && !long_reset);
endmodule
`default_nettype wire

// ---- srcs_pkg.sv ----
// constants for the reset and bus-clock sequencer
// assumes a single clock domain driven by the buffered oscillator clock
//
// How it works
// - bus clock is source divided by four
// - power/low-voltage reset holds clocks, pin 4128
// - stop exit waits delay before clocks
// - short recovery bit picks 32 cycles
// - any reset asserts internal reset, picks vector
// - internal reset clears counter, pin reset not
// - each reset sets its cause flag
// - pin flag needs 67 cycles low
// - internal sources pin 32 then 32 more
// - power/low-voltage pin low 4096 plus 32
// - recovery 4160 or 64 cycles total
// - power-on sets its flag, clears others
// - power-on enables clock output, clocks held
// - watchdog overflow resets, sets flag
// - watchdog disabled by test high voltage
// - bad opcode or disabled stop resets
// - only opcode fetch from unmapped resets
// - monitor entry erased vectors resets
// - twelve-bit counter is watchdog prescaler
// - stop instruction clears the counter
// - counter runs freely after reset
package srcs_pkg;
	localparam int CNT_W = 12;
	localparam int OSC_MHZ = 25;
	localparam int LONG_DLY_CYC = 4096;
	localparam int SHORT_DLY_CYC = 32;
	localparam int PIN_DRIVE_CYC = 32;
	localparam int INTERNAL_RESET_SIGNAL_EXTRA_CYC = 32;
	localparam int PIN_MIN_LOW_CYC = 67;
	localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
	localparam logic [15:0] VEC_MONITOR = 16'hFEFE;
	localparam logic [7:0] CAUSE_RESET = 8'h80;
	// cause register bit positions
	localparam int B_POR = 7;
	localparam int B_PIN = 6;
	localparam int B_WDOG = 5;
	localparam int B_OPC = 4;
	localparam int B_ADR = 3;
	localparam int B_MON = 2;
	localparam int B_LV = 1;
	typedef enum logic [4:0] {
		SRCS_RUN = 5'h01,
		SRCS_LONG = 5'h02,
		SRCS_DRIVE = 5'h04,
		SRCS_HOLD = 5'h08,
		SRCS_STOP = 5'h10
	} srcs_state_t;
endpackage

// ---- srcs_pin_model.sv ----
// reset pin far side: pull-up resistor plus an outside driver
// assumes the sequencer drives low only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module srcs_pin_model (
	input wire logic pull_low_i,
	input wire logic pin_drv_i,
	input wire logic pin_oe_i,
	output logic pin_o
);
	// pull-up wins once nobody drives low
	assign pin_o = !(pull_low_i || (pin_oe_i && !pin_drv_i));
endmodule
`default_nettype wire

// ---- srcs_sequencer_tb.sv ----
// self-checking bench for the reset and bus-clock sequencer
// assumes LONG_CYC shortened to 64 and the pin model on the reset pin
`timescale 1ns/1ps
`default_nettype none
module srcs_sequencer_tb import srcs_pkg::*;;
	logic core_clk_i = 1'h0;
	logic srst_i = 1'h1;
	logic [8:0] req = 9'h080;
	logic [3:0] wd = 4'h0;
	logic short_rec = 1'h0, wake = 1'h0, pull_low = 1'h0;
	logic pll_sel = 1'h0, pll_clk = 1'h0;
	logic pin, pin_drv, oe, internal_reset_signal, bus_clk, cgo, wdis;
	logic [15:0] vec;
	logic [7:0] cause;
	logic [CNT_W-1:0] cnt, c0;
	int num_errors = 0, n_compared = 0, n, r;
	// request bits, cause, drive length
	localparam logic [24:0] ROWS [8] = '{{9'h081, 8'h20, 8'h20},
		{9'h082, 8'h10, 8'h20}, {9'h08C, 8'h08, 8'h20},
		{9'h090, 8'h04, 8'h20}, {9'h020, 8'h10, 8'h20},
		{9'h084, 8'h00, 8'h00}, {9'h0C0, 8'h02, 8'h60},
		{9'h180, 8'h80, 8'h60}};
	always #20 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) pll_clk <= ~pll_clk;
	srcs_pin_model srcs_pin_model_i (.pull_low_i(pull_low),
		.pin_drv_i(pin_drv), .pin_oe_i(oe), .pin_o(pin));
	srcs_sequencer #(.LONG_CYC(64)) srcs_sequencer_i (
		.core_clk_i(core_clk_i), .srst_i(srst_i),
		.power_up_pulse_i(req[8]), .low_voltage_i(req[6]),
		.watchdog_ovf_i(req[0]), .bad_opcode_i(req[1]),
		.stop_exec_i(req[5]), .stop_enable_i(req[7]),
		.fetch_unmapped_i(req[2]), .opcode_fetch_i(req[3]),
		.monitor_entry_reset_i(req[4]), .monitor_mode_i(wd[3]),
		.rst_test_high_voltage_i(wd[2]), .irq_test_high_voltage_i(wd[1]),
		.break_i(wd[0]), .short_recovery_bit_i(short_rec),
		.stop_wake_i(wake), .pll_select_i(pll_sel),
		.pll_output_clock_i(pll_clk), .rst_pin_i(pin),
		.rst_pin_o(pin_drv),
		.rst_pin_oe_o(oe), .internal_reset_signal_o(internal_reset_signal),
		.bus_clk_o(bus_clk), .clock_gen_output_o(cgo),
		.reset_vector_o(vec), .reset_cause_register_o(cause),
		.counter_o(cnt), .watchdog_disable_o(wdis));
	// ==========================================================
	// shared tasks
	task automatic step;
		@(posedge core_clk_i);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'h1) begin
			num_errors++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	task automatic seq(input int ln, input logic [7:0] cs);
		int a, b;
		logic bz;
		a = 0;
		b = 0;
		bz = 1'h0;
		while (oe === 1'h1 && a < 300) begin
			bz |= bus_clk;
			step;
			a++;
		end
		while (internal_reset_signal === 1'h1 && b < 300) begin
			bz |= bus_clk;
			step;
			b++;
		end
		chk(a == ln, "pin drive length");
		chk(b == (ln ? 32 : 0), "reset hold length");
		chk(bz === 1'h0, "bus clock ran in reset");
		if (ln) chk(cause === cs, "cause flags");
		if (ln) chk(cnt < ln + 40, "counter not cleared");
	endtask
	task automatic close_out;
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge core_clk_i);
		srst_i <= 1'h0;
		#1;
		chk(cause === CAUSE_RESET, "reset flags");
		chk(oe && internal_reset_signal && cgo, "reset start");
		chk(pin_drv === 1'h0, "pin not driven low");
		for (n = 0; internal_reset_signal !== 1'h0 && n < 300; n++) step;
		chk(n >= 127 && n <= 129, "long recovery");
		c0 = cnt;
		r = 0;
		for (n = 0; n < 40; n++) begin
			wd <= 4'h0;
			step;
		end
		chk(cnt - c0 === 12'h028, "free counter");
		for (n = 0; n < 40; n++) begin
			c0[0] = bus_clk;
			step;
			if (bus_clk === 1'h1 && c0[0] === 1'h0) r++;
		end
		chk(r == 10, "bus clock divide");
		// pll source rising every two cycles gives an eight-cycle bus clock
		@(posedge core_clk_i) pll_sel <= 1'h1;
		repeat (8) step;
		r = 0;
		for (n = 0; n < 40; n++) begin
			c0[0] = bus_clk;
			step;
			if (bus_clk === 1'h1 && c0[0] === 1'h0) r++;
		end
		chk(r == 5, "pll bus clock divide");
		@(posedge core_clk_i) pll_sel <= 1'h0;
		for (int k = 0; k < 16; k++) begin
			@(posedge core_clk_i) wd <= k[3:0];
			step;
			chk(wdis === (wd[3] & (wd[2] | wd[1]) | wd[0] & wd[2]),
				"watchdog disable");
			chk(vec === (wd[3] ? VEC_MONITOR : VEC_NORMAL), "vector");
		end
		@(posedge core_clk_i) wd <= 4'h0;
		for (int k = 0; k < 8; k++) begin
			repeat (150) @(posedge core_clk_i);
			req <= ROWS[k][24:16];
			@(posedge core_clk_i) req <= 9'h080;
			#1;
			seq(ROWS[k][7:0], ROWS[k][15:8]);
		end
		// stop entry, then wake two cycles later
		for (int s = 0; s < 2; s++) begin
			@(posedge core_clk_i) short_rec <= s[0];
			req <= 9'h0A0;
			@(posedge core_clk_i) req <= 9'h080;
			#1;
			chk(cnt < 12'h003, "stop clears counter");
			@(posedge core_clk_i) wake <= 1'h1;
			@(posedge core_clk_i) wake <= 1'h0;
			for (n = 0; bus_clk !== 1'h1 && n < 200; n++) step;
			r = s ? 32 : 64;
			chk(n >= r - 4 && n <= r + 6, "stop delay");
		end
		// glitch too short, then a long outside pull
		@(posedge core_clk_i) pull_low <= 1'h1;
		repeat (20) @(posedge core_clk_i);
		pull_low <= 1'h0;
		repeat (10) step;
		chk(cause === 8'h80 && oe === 1'h0, "short pin pulse");
		repeat (150) @(posedge core_clk_i);
		pull_low <= 1'h1;
		repeat (80) @(posedge core_clk_i);
		pull_low <= 1'h0;
		for (n = 0; internal_reset_signal !== 1'h0 && n < 300; n++) step;
		chk(cause === 8'h40, "pin flag");
		chk(cnt > 12'h0C8, "pin keeps counter");
		close_out;
	end
	initial begin
		#(40 * 20000);
		num_errors++;
		close_out;
	end
endmodule
`default_nettype wire
